// [dv/prda_coupler.sv]
// Coupler model: sends one process-data image per go pulse, keeps the answer.
// Assumes go pulses respect the answer spacing.
`timescale 1ns/100ps
`default_nettype none
module prda_coupler (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	// Bench side
	input  wire logic                   go,
	input  wire prda_pkg::prda_pd_out_t req,
	output prda_pkg::prda_pd_in_t       answer,
	output logic                        done,
	// Block side
	output logic                        pd_out_valid,
	output prda_pkg::prda_pd_out_t      pd_out,
	input  wire logic                   pd_in_valid,
	input  wire prda_pkg::prda_pd_in_t  pd_in
);
	// Idle image toggles so a stale sample cannot pass by chance
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pd_out_valid <= 1'b0;
			pd_out       <= 24'h000000;
			done         <= 1'b0;
			answer       <= 24'h000000;
		end else begin
			pd_out_valid <= go;
			pd_out       <= go ? req : ~pd_out;
			done         <= pd_in_valid;
			if (pd_in_valid)
				answer <= pd_in;
		end
	end
endmodule // prda_coupler
`default_nettype wire

// [dv/prda_regbank_props.sv]
// Port assertions for the register access block.
// Assumes the coupler keeps request spacing.
`timescale 1ns/100ps
`default_nettype none
module prda_regbank_props (
	// Clock and reset
	input wire logic                   clk,
	input wire logic                   rst_n,
	// Process data
	input wire logic                   pd_out_valid,
	input wire prda_pkg::prda_pd_out_t pd_out,
	input wire logic                   pd_in_valid,
	input wire prda_pkg::prda_pd_in_t  pd_in,
	// Application
	input wire prda_pkg::prda_pd_in_t  app_pd_in,
	input wire prda_pkg::prda_pd_out_t app_pd_out,
	input wire logic                   app_pd_out_valid,
	// Configuration
	input wire logic [15:0]            terminal_feature_bits,
	input wire logic                   write_unlocked
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_n);
	wire logic [7:0] ctl = pd_out.control_byte;
	wire logic       rq  = pd_out_valid && ctl[7];
	write_ack_a: assert property (rq && ctl[6] |-> ##2 pd_in_valid
		&& pd_in.status_byte == ($past(ctl, 2) & 8'hbf)) else $error("write ack wrong");
	read_ack_a: assert property (rq && !ctl[6] |-> ##2 pd_in_valid && pd_in.status_byte == $past(ctl, 2))
		else $error("read ack wrong");
	read_gap_a: assert property (rq && !ctl[6] |=> !pd_in_valid)
		else $error("read answered early");
	normal_pass_a: assert property (pd_out_valid && !ctl[7] |=> app_pd_out_valid
		&& app_pd_out == $past(pd_out) && pd_in == $past(app_pd_in)) else $error("normal exchange wrong");
	reg_quiet_a: assert property (rq |=> !app_pd_out_valid)
		else $error("register request leaked");
	code_lock_a: assert property (pd_out_valid && ctl == 8'hdf |=>
		write_unlocked == ($past(pd_out.output_data_word) == 16'h1235)) else $error("lock state wrong");
	feature_wr_a: assert property ($changed(terminal_feature_bits) |-> $past(pd_out_valid && ctl == 8'he0
		&& write_unlocked) && terminal_feature_bits == $past(pd_out.output_data_word)) else $error("feature bad");
	feature_rd_a: assert property (pd_out_valid && ctl == 8'ha0 |-> ##2 pd_in.input_data_word == terminal_feature_bits)
		else $error("feature read wrong");
endmodule // prda_regbank_props
bind prda_regbank prda_regbank_props i_props (.clk(clk), .rst_n(rst_n), .pd_out_valid(pd_out_valid),
	.pd_out(pd_out), .pd_in_valid(pd_in_valid), .pd_in(pd_in), .app_pd_in(app_pd_in), .app_pd_out(app_pd_out),
	.app_pd_out_valid(app_pd_out_valid), .terminal_feature_bits(terminal_feature_bits),
	.write_unlocked(write_unlocked));
`default_nettype wire

// [dv/prda_regbank_test.sv]
// Bench for the register access block.
// Assumes the coupler model beside it.
`timescale 1ns/100ps
`default_nettype none
module prda_regbank_test;
	logic                   clk    = 1'b0;
	logic                   rst_n  = 1'b0;
	logic                   go     = 1'b0;
	prda_pkg::prda_pd_out_t req    = 24'h000000;
	prda_pkg::prda_pd_in_t  app_in = 24'h000000;
	wire logic              pvld, pivld, apvld, unl, done;
	prda_pkg::prda_pd_out_t pout, apout;
	prda_pkg::prda_pd_in_t  pin, answer;
	logic [15:0]            feat;
	int                     fails  = 0;
	int                     checks = 0;
	int                     cycles = 0;
	always #4 clk = ~clk;
	prda_regbank i_prda_regbank (.clk(clk), .rst_n(rst_n), .pd_out_valid(pvld), .pd_out(pout),
		.pd_in_valid(pivld), .pd_in(pin), .app_pd_in(app_in), .app_pd_out(apout),
		.app_pd_out_valid(apvld), .terminal_feature_bits(feat), .write_unlocked(unl));
	prda_coupler i_prda_coupler (.clk(clk), .rst_n(rst_n), .go(go), .req(req), .answer(answer),
		.done(done), .pd_out_valid(pvld), .pd_out(pout), .pd_in_valid(pivld), .pd_in(pin));
	task chk(input logic [23:0] got, input logic [23:0] exp);
		checks++;
		if (got !== exp) begin
			fails++;
			$display("[ERR] %0t got %h exp %h", $time, got, exp);
		end
	endtask
	task close_out;
		$display("checks %0d fails %0d", checks, fails);
		if (fails == 0 && checks > 0)
			$display("Simulation passed");
		else
			$display("Simulation failed");
		$finish;
	endtask
	// One request, wait for the answer, then idle past the spacing
	task xfer(input logic [7:0] c, input logic [15:0] w, input logic [23:0] exp);
		int n;
		n = 0;
		@(posedge clk);
		go  <= 1'b1;
		req <= {c, w};
		@(posedge clk);
		go <= 1'b0;
		while (done !== 1'b1 && n < 20) begin
			@(posedge clk);
			n++;
		end
		if (n == 20) begin
			fails++;
			$display("[ERR] %0t no answer", $time);
		end
		chk(answer, exp);
		repeat (3) @(posedge clk);
	endtask
	always @(posedge clk) begin
		cycles++;
		if (cycles == 1000) begin
			fails++;
			close_out();
		end
	end
	initial begin
		repeat (6) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk({7'h00, unl, feat}, 24'h000000);
		xfer(8'h9f, 16'ha5a5, 24'h9f0000);
		xfer(8'he0, 16'h0002, 24'ha00000);
		chk({7'h00, unl, feat}, 24'h000000);
		xfer(8'hdf, 16'h1235, 24'h9f0000);
		xfer(8'h9f, 16'h5a5a, 24'h9f1235);
		xfer(8'he0, 16'h0002, 24'ha00000);
		xfer(8'ha0, 16'hffff, 24'ha00002);
		xfer(8'hc5, 16'hbeef, 24'h850000);
		xfer(8'h85, 16'h0000, 24'h85beef);
		chk({7'h00, unl, feat}, 24'h010002);
		xfer(8'hdf, 16'h1234, 24'h9f0000);
		xfer(8'he0, 16'h00f0, 24'ha00000);
		xfer(8'hdf, 16'h1235, 24'h9f0000);
		xfer(8'hdf, 16'h0000, 24'h9f0000);
		chk({7'h00, unl, feat}, 24'h000002);
		app_in <= 24'h778899;
		xfer(8'h12, 16'h3456, 24'h778899);
		chk(apout, 24'h123456);
		rst_n <= 1'b0;
		repeat (2) @(posedge clk);
		rst_n <= 1'b1;
		@(posedge clk);
		chk({7'h00, unl, feat}, 24'h000000);
		close_out();
	end
endmodule // prda_regbank_test
`default_nettype wire

// [verilog/prda_pkg.sv]
// Package for the process-data register access block.
// Holds control-byte fields, register numbers, reset values and the process-data carriers.
package prda_pkg;

	// Control byte fields
	localparam int unsigned CTRL_REG_MODE_BIT = 7;
	localparam int unsigned CTRL_WRITE_BIT    = 6;
	localparam int unsigned CTRL_NUM_MSB      = 5;
	localparam int unsigned CTRL_NUM_LSB      = 0;
	localparam int unsigned REG_NUM_W         = 6;
	localparam int unsigned DATA_W            = 16;
	localparam int unsigned BYTE_W            = 8;

	// Register numbers
	localparam logic [5:0] REG_WRITE_UNLOCK_CODE     = 6'h1f;
	localparam logic [5:0] REG_TERMINAL_FEATURE_BITS = 6'h20;

	// Unlock value and protecting value
	localparam logic [15:0] UNLOCK_CODE_VALUE = 16'h1235;
	localparam logic [15:0] LOCK_CODE_VALUE   = 16'h0000;

	// Values after reset
	localparam logic [15:0] WRITE_UNLOCK_CODE_RST     = 16'h0000;
	localparam logic [15:0] TERMINAL_FEATURE_BITS_RST = 16'h0000;
	localparam logic [7:0]  STATUS_BYTE_RST           = 8'h00;
	localparam logic [15:0] INPUT_DATA_WORD_RST       = 16'h0000;
	localparam logic [15:0] INVALID_DATA_WORD         = 16'h0000;

	// Request-to-answer cycle constants; the block uses neither and answers both reads and writes 2 cycles after the request
	localparam int unsigned WRITE_ANSWER_CYCLES = 1;
	localparam int unsigned READ_ANSWER_CYCLES  = 2;

	// Outgoing process data from the coupler: control byte, output data word
	typedef struct packed {
		logic [7:0]  control_byte;
		logic [15:0] output_data_word;
	} prda_pd_out_t;

	// Incoming process data to the coupler: status byte, input data word
	typedef struct packed {
		logic [7:0]  status_byte;
		logic [15:0] input_data_word;
	} prda_pd_in_t;

endpackage

// [verilog/prda_regbank.sv]
// Summary of operation
// (RQ1) Control bit 7 set selects register access
// (RQ2) Control bit 6 clear requests a read
// (RQ3) Control bit 6 set writes output word
// (RQ4) Control bits 5..0 give register number
// (RQ5) Output data word ignored during reads
// (RQ6) Read acknowledged by copying the control byte
// (RQ7) Feature register read returns its content
// (RQ8) Code-word register read returns stored value
// (RQ9) Controller supplies new value with write
// (RQ10) Write acknowledged with bit 6 cleared
// (RQ11) Input word invalid after write acknowledge
// (RQ12) Zero in code word restores protection
// (RQ13) Feature bits steer terminal operating properties
// (RQ14) Status byte 0, data word bytes 1-2
// (RQ15) Locked: only code-word register is writable
// (RQ16) Value 0x1235 lifts write protection
// (RQ17) Any other code value restores protection
// (RQ18) Byte 1 high, byte 2 low
// (RQ19) Controller holds request until acknowledged
//
// Register access path carried in cyclic process data.
// Assumes one process-data exchange per pd_out_valid pulse from the coupler side,
// and a terminal application that supplies its own normal process data.
`timescale 1ns/100ps
`default_nettype none

module prda_regbank #(
	parameter int unsigned REG_DEPTH = 64
) (
	// Clock and reset
	input  wire logic                   clk,
	input  wire logic                   rst_n,
	// Outgoing process data from the coupler
	input  wire logic                   pd_out_valid,
	input  wire prda_pkg::prda_pd_out_t pd_out,
	// Incoming process data to the coupler
	output logic                        pd_in_valid,
	output prda_pkg::prda_pd_in_t       pd_in,
	// Terminal application, normal process data
	input  wire prda_pkg::prda_pd_in_t  app_pd_in,
	output prda_pkg::prda_pd_out_t      app_pd_out,
	output logic                        app_pd_out_valid,
	// Terminal configuration
	output logic [15:0]                 terminal_feature_bits,
	output logic                        write_unlocked
);

	typedef enum logic [1:0] {
		PRDA_IDLE,
		PRDA_READ_WAIT,
		PRDA_WRITE_ACK
	} prda_state_t;

	prda_state_t  state;
	prda_state_t  next_state;

	logic [7:0]   req_ctrl;
	logic [15:0]  write_unlock_code;
	logic [15:0]  mem_rd_data;
	logic         unlocked;

	// Fields of the incoming control byte
	wire logic        in_reg_mode = pd_out.control_byte[prda_pkg::CTRL_REG_MODE_BIT];  // [RQ1]
	wire logic        in_is_write = pd_out.control_byte[prda_pkg::CTRL_WRITE_BIT];     // [RQ2] [RQ3]
	wire logic [5:0]  in_reg_num  =
		pd_out.control_byte[prda_pkg::CTRL_NUM_MSB:prda_pkg::CTRL_NUM_LSB];            // [RQ4]
	wire logic [15:0] in_word     = pd_out.output_data_word;                           // [RQ9] [RQ18]

	// Request strobes
	wire logic reg_req   = pd_out_valid && in_reg_mode && (state == PRDA_IDLE);
	wire logic read_req  = reg_req && !in_is_write;                                   // [RQ2]
	wire logic write_req = reg_req && in_is_write;                                    // [RQ3]

	// Register selection
	wire logic hit_code    = (in_reg_num == prda_pkg::REG_WRITE_UNLOCK_CODE);
	wire logic hit_feature = (in_reg_num == prda_pkg::REG_TERMINAL_FEATURE_BITS);

	// Write protection: only the code-word register passes while locked
	wire logic next_unlocked = (in_word == prda_pkg::UNLOCK_CODE_VALUE);              // [RQ16] [RQ17] [RQ12]
	wire logic write_allowed = hit_code || unlocked;                                  // [RQ15]
	wire logic code_wr       = write_req && hit_code;
	wire logic feature_wr    = write_req && hit_feature && unlocked;                  // [RQ15]
	// A shallower memory drops writes beyond its depth instead of aliasing them
	wire logic in_range      = (in_reg_num < REG_DEPTH);
	wire logic mem_wr        = write_req && write_allowed && in_range && !hit_code && !hit_feature;

	// Held request fields for the read answer
	wire logic [5:0] req_num      = req_ctrl[prda_pkg::CTRL_NUM_MSB:prda_pkg::CTRL_NUM_LSB];
	wire logic       req_code     = (req_num == prda_pkg::REG_WRITE_UNLOCK_CODE);
	wire logic       req_feature  = (req_num == prda_pkg::REG_TERMINAL_FEATURE_BITS);
	wire logic       req_in_range = (req_num < REG_DEPTH);

	// Read data: flop-held registers shadow their memory words
	wire logic [15:0] read_word =
		req_code     ? write_unlock_code :                                            // [RQ8]
		req_feature  ? terminal_feature_bits :                                        // [RQ7]
		req_in_range ? mem_rd_data :
		prda_pkg::INVALID_DATA_WORD;

	// Acknowledge bytes
	wire logic [7:0] read_ack  = req_ctrl;                                            // [RQ6]
	wire logic [7:0] write_ack =
		req_ctrl & ~(8'h01 << prda_pkg::CTRL_WRITE_BIT);                             // [RQ10]

	// Memory for the remaining user registers; the write port sees only allowed writes
	prda_regmem #(
		.WIDTH (prda_pkg::DATA_W),
		.DEPTH (REG_DEPTH),
		.AW    (prda_pkg::REG_NUM_W)
	) u_regmem (
		.clk     (clk),
		.wr_en   (mem_wr),
		.wr_addr (in_reg_num),
		.wr_data (in_word),
		.rd_addr (in_reg_num),
		.rd_data (mem_rd_data)
	);

	// Sequencer: a read needs one extra cycle for the registered memory read
	always_comb begin
		next_state = state;
		case (state)
			PRDA_IDLE: begin
				if (read_req) begin
					next_state = PRDA_READ_WAIT;
				end else if (write_req) begin
					next_state = PRDA_WRITE_ACK;
				end
			end
			PRDA_READ_WAIT: begin
				next_state = PRDA_IDLE;
			end
			PRDA_WRITE_ACK: begin
				next_state = PRDA_IDLE;
			end
			default: begin
				next_state = PRDA_IDLE;
			end
		endcase
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			state <= PRDA_IDLE;
		end else begin
			state <= next_state;
		end
	end

	// Request capture; the output word is not captured for reads
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			req_ctrl <= prda_pkg::STATUS_BYTE_RST;
		end else if (reg_req) begin
			req_ctrl <= pd_out.control_byte;                                          // [RQ5]
		end
	end

	// Code-word register: any write lands, the value decides the lock
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			write_unlock_code <= prda_pkg::WRITE_UNLOCK_CODE_RST;
		end else if (code_wr) begin
			write_unlock_code <= in_word;                                             // [RQ12] [RQ16] [RQ17]
		end
	end

	// Lock flag kept in a flop beside the code word, so the exported level never glitches
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			unlocked <= (prda_pkg::WRITE_UNLOCK_CODE_RST == prda_pkg::UNLOCK_CODE_VALUE);
		end else if (code_wr) begin
			unlocked <= next_unlocked;                                                // [RQ12] [RQ16] [RQ17]
		end
	end

	// Feature register drives the terminal's operating options
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			terminal_feature_bits <= prda_pkg::TERMINAL_FEATURE_BITS_RST;
		end else if (feature_wr) begin
			terminal_feature_bits <= in_word;                                         // [RQ13]
		end
	end

	assign write_unlocked = unlocked;

	// Normal process data passes straight to the application when not in register mode
	wire logic next_app_pd_out_valid = pd_out_valid && !in_reg_mode;                  // [RQ1]

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			app_pd_out_valid <= 1'b0;
		end else begin
			app_pd_out_valid <= next_app_pd_out_valid;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			app_pd_out <= '0;
		end else if (next_app_pd_out_valid) begin
			app_pd_out <= pd_out;                                                     // [RQ1]
		end
	end

	// Answer selection. A request that arrives while one is in flight is dropped;
	// the controller holds its request until acknowledged, so it is retaken next exchange.
	wire logic        answer_read      = (state == PRDA_READ_WAIT);
	wire logic        answer_write     = (state == PRDA_WRITE_ACK);
	wire logic        answer_normal    = (state == PRDA_IDLE) && next_app_pd_out_valid;   // [RQ1]
	wire logic        next_pd_in_valid = answer_read || answer_write || answer_normal;
	wire logic [7:0]  next_status_byte =
		answer_read  ? read_ack :                                                     // [RQ6] [RQ14]
		answer_write ? write_ack :                                                    // [RQ10] [RQ14]
		app_pd_in.status_byte;                                                        // [RQ1]
	wire logic [15:0] next_input_word  =
		answer_read  ? read_word :                                                    // [RQ7] [RQ8] [RQ18]
		answer_write ? prda_pkg::INVALID_DATA_WORD :                                  // [RQ11]
		app_pd_in.input_data_word;

	// Answer registers hold until the next answer, as the coupler may sample late
	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pd_in.status_byte     <= prda_pkg::STATUS_BYTE_RST;
			pd_in.input_data_word <= prda_pkg::INPUT_DATA_WORD_RST;
		end else if (next_pd_in_valid) begin
			pd_in.status_byte     <= next_status_byte;
			pd_in.input_data_word <= next_input_word;
		end
	end

	always_ff @(posedge clk or negedge rst_n) begin
		if (!rst_n) begin
			pd_in_valid <= 1'b0;
		end else begin
			pd_in_valid <= next_pd_in_valid;
		end
	end

endmodule // prda_regbank

`default_nettype wire

// [verilog/prda_regmem.sv]
// Small user register memory: one write port, one read port with registered read data.
// Assumes the caller filters protected writes; contents have no reset.
`timescale 1ns/100ps
`default_nettype none

module prda_regmem #(
	parameter int unsigned WIDTH = 16,
	parameter int unsigned DEPTH = 64,
	parameter int unsigned AW    = 6
) (
	// Clock
	input  wire logic             clk,
	// Write port
	input  wire logic             wr_en,
	input  wire logic [AW-1:0]    wr_addr,
	input  wire logic [WIDTH-1:0] wr_data,
	// Read port
	input  wire logic [AW-1:0]    rd_addr,
	output logic      [WIDTH-1:0] rd_data
);

	logic [WIDTH-1:0] mem [DEPTH];

	always_ff @(posedge clk) begin
		if (wr_en) begin
			mem[wr_addr] <= wr_data;
		end
		rd_data <= mem[rd_addr];
	end

endmodule // prda_regmem

`default_nettype wire
